// ===== bench/config_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// host side of the serial port; shift clock idles low and stands still between bursts
module config_host_model (
    output logic shiftClk, // pulled low when idle
    output logic serialSelectN, // select, active low
    output logic serialInputLine // serial data
);
    initial begin
        shiftClk = 1'b0;
        serialSelectN = 1'b1;
        serialInputLine = 1'b0;
    end
    // select low with setup margin before the first edge
    task automatic open_burst();
        serialSelectN = 1'b0;
        #30;
    endtask
    // address first, msb first; a partial word stops one bit short
    task automatic send_word(input logic [15:0] w, input bit partial);
        // clock stands still between words so the held word outlives the core's crossing
        #400;
        for (int b = 15; b >= (partial ? 1 : 0); b--) begin
            shiftClk = 1'b1;
            #1;
            serialInputLine = w[b]; // changes after the rising edge
            #4;
            shiftClk = 1'b0; // uneven duty: 5 ns high, 7 ns low
            #7;
        end
    endtask
    // released line shows the inverse so a stale bit never looks valid
    task automatic close_burst();
        #30;
        serialSelectN = 1'b1;
        serialInputLine = ~serialInputLine;
    endtask
    // static strap levels on the clock and data pins
    task automatic hold_pins(input logic c, input logic dv);
        shiftClk = c;
        serialInputLine = dv;
    endtask
endmodule // config_host_model
`default_nettype wire

// ===== bench/converter_config_port_chk.sv
`timescale 1ns/100ps
`default_nettype none
// port-level checks; strap relations allow sync plus decode latency
module converter_config_port_chk
    import converter_config_pkg::*;
#(
    parameter int SYNC_DEPTH = SYNC_STAGES // same as the block
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic shiftClk,
    input wire logic serialSelectN,
    input wire logic serialInputLine,
    input wire logic resetPin,
    input wire logic [1:0] selectStrapLevel,
    input wire logic [1:0] modeStrapOne,
    input wire logic [1:0] modeStrapTwo,
    input wire logic [1:0] modeStrapFour,
    input wire logic chanASleepPin,
    input wire logic chanBSleepPin,
    input wire logic powerDownPin,
    input wire logic strapMode,
    input wire logic writeStrobe,
    input wire converter_cfg_t cfg
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    chk_strobe_serial: assert property (writeStrobe |-> !strapMode)
        else $error("write strobe in strap mode");
    chk_mode_enter: assert property (resetPin [*4] |-> strapMode)
        else $error("strap mode not entered");
    chk_gpd_pin: assert property (powerDownPin [*5] |-> cfg.globalPowerDown)
        else $error("power down pin ignored");
    chk_sleep_a: assert property (chanASleepPin [*5] |-> cfg.chanAPowerDown)
        else $error("channel a sleep ignored");
    chk_strap_ref: assert property ((resetPin && selectStrapLevel == LVL_GND) [*6] |-> cfg.externalRef && !cfg.coarseGain)
        else $error("select strap ground decode");
    chk_strap_sync: assert property ((resetPin && !shiftClk && serialInputLine) [*6] |-> cfg.testPattern == PAT_SYNC)
        else $error("sync strap decode");
    chk_strap_pdown: assert property ((resetPin && shiftClk && !serialInputLine) [*6] |-> cfg.globalPowerDown)
        else $error("power down strap decode");
    chk_strap_wire: assert property ((resetPin && modeStrapOne == LVL_HIGH_MID) [*6] |-> cfg.twoWire && cfg.sdrClock)
        else $error("strap one decode");
    chk_regs_cleared: assert property (resetPin [*6] |-> cfg.fineGain == 3'h0 && cfg.driveTermination == 11'h000)
        else $error("registers not held clear");
    cover property (writeStrobe);
    cover property (strapMode && cfg.testPattern == PAT_DESKEW);
    cover property (!strapMode && cfg.coarseGain);
endmodule // converter_config_port_chk
bind converter_config_port converter_config_port_chk #(.SYNC_DEPTH(SYNC_DEPTH)) u_chk (.clk(clk), .rstn(rstn),
    .shiftClk(shiftClk), .serialSelectN(serialSelectN), .serialInputLine(serialInputLine), .resetPin(resetPin),
    .selectStrapLevel(selectStrapLevel), .modeStrapOne(modeStrapOne), .modeStrapTwo(modeStrapTwo),
    .modeStrapFour(modeStrapFour), .chanASleepPin(chanASleepPin), .chanBSleepPin(chanBSleepPin),
    .powerDownPin(powerDownPin), .strapMode(strapMode), .writeStrobe(writeStrobe), .cfg(cfg));
`default_nettype wire

// ===== bench/converter_config_port_test.sv
`timescale 1ns/100ps
`default_nettype none
module converter_config_port_test;
    import converter_config_pkg::*;
    logic clk, rstn, resetPin, chanASleepPin, chanBSleepPin, powerDownPin, strapMode, writeStrobe, pend, pend2;
    logic [1:0] selectStrapLevel, modeStrapOne, modeStrapTwo, modeStrapFour;
    wire logic shiftClk, serialSelectN, serialInputLine;
    converter_cfg_t cfg;
    converter_cfg_t notes [$]; // expected cfg, one per accepted write
    logic [10:0] bank [32]; // mirror of the register bank
    logic [4:0] a;
    logic [10:0] d;
    logic [31:0] rnd;
    int n_errors, n_checks, seed, i, k;
    localparam logic [4:0] MAP [8] = '{5'h00, 5'h04, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h10, 5'h11}; // last unmapped
    converter_config_port u_converter_config_port (.clk(clk), .rstn(rstn), .shiftClk(shiftClk),
        .serialSelectN(serialSelectN), .serialInputLine(serialInputLine), .resetPin(resetPin),
        .selectStrapLevel(selectStrapLevel), .modeStrapOne(modeStrapOne), .modeStrapTwo(modeStrapTwo),
        .modeStrapFour(modeStrapFour), .chanASleepPin(chanASleepPin), .chanBSleepPin(chanBSleepPin),
        .powerDownPin(powerDownPin), .strapMode(strapMode), .writeStrobe(writeStrobe), .cfg(cfg));
    config_host_model u_config_host_model (.shiftClk(shiftClk), .serialSelectN(serialSelectN),
        .serialInputLine(serialInputLine));
    // effective configuration from mirror, pins and straps
    function automatic converter_cfg_t exp_cfg();
        converter_cfg_t c;
        logic [10:0] r;
        r = bank[ADDR_IFACE_CFG];
        c = '0;
        c.chanAPowerDown = chanASleepPin | bank[0][BIT_PDN_CHA];
        c.chanBPowerDown = chanBSleepPin | bank[0][BIT_PDN_CHB];
        c.globalPowerDown = powerDownPin | bank[0][BIT_PDN_GLOBAL];
        c.externalRef = bank[0][BIT_EXT_REF];
        c.coarseGain = r[BIT_OVERRIDE] & r[BIT_COARSE_GAIN];
        c.testPattern = bank[ADDR_FORMAT_PAT][7:5];
        if (resetPin) begin // link pins act as straps
            c.globalPowerDown = powerDownPin | (shiftClk & !serialInputLine);
            c.testPattern = !serialInputLine ? PAT_NORMAL : shiftClk ? PAT_DESKEW : PAT_SYNC;
            c.externalRef = selectStrapLevel <= LVL_LOW_MID;
            c.coarseGain = selectStrapLevel inside {LVL_LOW_MID, LVL_HIGH_MID};
        end
        c.twoWire = r[BIT_OVERRIDE] ? r[BIT_TWO_WIRE] : modeStrapOne >= LVL_HIGH_MID;
        c.sdrClock = r[BIT_OVERRIDE] ? r[BIT_SDR] : modeStrapOne == LVL_HIGH_MID;
        c.serialize14 = r[BIT_OVERRIDE] ? r[BIT_SER14] : modeStrapTwo inside {1, 2};
        c.captureRising = r[BIT_OVERRIDE] ? r[BIT_RISE_CAPTURE] : modeStrapTwo >= LVL_HIGH_MID;
        c.lsbFirst = r[BIT_OVERRIDE] ? r[BIT_LSB_FIRST] : modeStrapFour >= LVL_HIGH_MID;
        c.offsetBinary = r[BIT_OVERRIDE] ? bank[ADDR_FORMAT_PAT][BIT_OFFSET_BIN] : modeStrapFour inside {1, 2};
        c.bitWise = r[BIT_OVERRIDE] & r[BIT_BIT_WISE];
        c.clockInGain = bank[ADDR_CLK_GAIN][6:2];
        c.customPattern = {bank[ADDR_FINE_GAIN][0], bank[ADDR_CUSTOM_LOW]};
        c.fineGain = bank[ADDR_FINE_GAIN][10:8];
        c.driveTermination = bank[ADDR_DRIVE_TERM];
        return c;
    endfunction
    task automatic compare(input converter_cfg_t e);
        n_checks++;
        if (cfg !== e) begin
            n_errors++;
            $display("[FAIL] %0t cfg %h expected %h", $time, cfg, e);
        end
    endtask
    // one word; mapped writes leave a note for the watcher
    task automatic wr(input logic [4:0] wa, input logic [10:0] wd);
        u_config_host_model.send_word({wa, wd}, 1'b0);
        if (wa == ADDR_POWER_REF && wd[BIT_SOFT_RESET]) begin
            foreach (bank[j]) bank[j] = '0;
        end else if (wa != 5'h11) begin
            bank[wa] = wd;
        end
        if (wa != 5'h11) begin
            notes.push_back(exp_cfg());
        end
    endtask
    task automatic give_verdict();
        if (n_errors == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // bank is written at the edge ending the strobe and cfg one edge later; compare after that
    always @(negedge clk) begin
        if (pend2) begin
            if (notes.size() == 0) begin
                n_errors++;
                $display("[FAIL] %0t unexpected write strobe", $time);
            end else begin
                compare(notes.pop_front());
            end
        end
        pend2 = pend;
        pend = (writeStrobe === 1'b1);
    end
    initial begin
        #1_000_000;
        n_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        give_verdict();
    end
    initial begin
        seed = 68518;
        {rstn, resetPin, chanASleepPin, chanBSleepPin, powerDownPin, pend, pend2} = '0;
        {selectStrapLevel, modeStrapOne, modeStrapTwo, modeStrapFour} = '0;
        foreach (bank[j]) bank[j] = '0;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk) resetPin <= 1'b1; // pulse clears the bank
        @(posedge clk) resetPin <= 1'b0; // low while programming
        repeat (6) @(posedge clk);
        compare(exp_cfg());
        for (i = 0; i < 24; i++) begin
            rnd = $random(seed);
            {modeStrapOne, modeStrapTwo, modeStrapFour, selectStrapLevel} <= rnd[7:0];
            {chanASleepPin, chanBSleepPin, powerDownPin} <= rnd[10:8];
            repeat (5) @(posedge clk);
            compare(exp_cfg());
            u_config_host_model.open_burst();
            for (k = 0; k < 3; k++) begin
                rnd = $random(seed);
                a = MAP[rnd[2:0]];
                d = rnd[18:8] & (a == 5'h00 ? 11'h02d : a == 5'h04 ? 11'h07c : a == 5'h0a ? 11'h2e0 :
                    a == 5'h0c ? 11'h701 : a == 5'h0d ? 11'h4f7 : 11'h7ff); // unused bits zero
                d[BIT_BIT_WISE] = d[BIT_BIT_WISE] & (a != 5'h0d || d[BIT_OVERRIDE]);
                wr(a, d); // back to back in one burst
            end
            if (i[0]) u_config_host_model.send_word({ADDR_CLK_GAIN, 11'h07c}, 1'b1);
            u_config_host_model.close_burst();
            repeat (8) @(posedge clk); // settle wait
        end
        u_config_host_model.open_burst();
        wr(ADDR_POWER_REF, 11'h42d);
        wr(ADDR_FINE_GAIN, 11'h501);
        u_config_host_model.close_burst();
        repeat (8) @(posedge clk);
        resetPin <= 1'b1;
        foreach (bank[j]) bank[j] = '0;
        for (i = 0; i < 16; i++) begin
            u_config_host_model.hold_pins(i[1], i[0]);
            {selectStrapLevel, modeStrapOne, modeStrapTwo, modeStrapFour} <= {i[3:2], i[3:2], i[1:0], i[1:0]};
            repeat (8) @(posedge clk);
            compare(exp_cfg());
        end
        u_config_host_model.hold_pins(1'b0, 1'b0);
        resetPin <= 1'b0;
        repeat (6) @(posedge clk);
        compare(exp_cfg());
        {selectStrapLevel, modeStrapOne, modeStrapTwo, modeStrapFour} <= '0;
        {chanASleepPin, chanBSleepPin} <= 2'b00;
        u_config_host_model.open_burst();
        wr(ADDR_IFACE_CFG, 11'h401);
        wr(ADDR_DRIVE_TERM, 11'h5a5);
        u_config_host_model.close_burst();
        repeat (8) @(posedge clk);
        rstn <= 1'b0;
        foreach (bank[j]) bank[j] = '0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (6) @(posedge clk);
        compare(exp_cfg());
        n_checks++;
        if (notes.size() != 0) begin
            n_errors++;
            $display("[FAIL] %0t missing write strobes", $time);
        end
        give_verdict();
    end
endmodule // converter_config_port_test
`default_nettype wire

// ===== common/converter_config_pkg.sv
// Summary of operation
// - shift data only while select low, falling edges
// - sixteenth falling edge writes the addressed register
// - trailing partial word bits are dropped silently
// - many words allowed in one select burst
// - five address bits first, then eleven data
// - any shift rate to 20 MHz, any duty
// - soft reset bit clears all, then self-clears
// - reset pin high turns serial pins into straps
// - straps one, two and four configure device after power-up, no reset
// - override bit high lets registers beat straps
// - power-down pin high forces global power down
// - serial mode coarse gain needs override bit
// - strap clock/data pins pick pattern or power down
// - select strap picks reference and coarse gain
// - channel sleep pin high powers channel down
// - strap one picks bit clock and wire count
// - strap two picks serialization and capture edge
// - strap four picks bit order and format
// - any reset clears every register bit
`default_nettype none
package converter_config_pkg;
    localparam int ADDR_W = 5; // address bits, sent first
    localparam int DATA_W = 11; // data bits after the address
    localparam int WORD_W = ADDR_W + DATA_W; // bits per serial word
    localparam int NUM_REGS = 7; // mapped registers
    localparam logic [4:0] ADDR_POWER_REF = 5'h00;
    localparam logic [4:0] ADDR_CLK_GAIN = 5'h04;
    localparam logic [4:0] ADDR_FORMAT_PAT = 5'h0a;
    localparam logic [4:0] ADDR_CUSTOM_LOW = 5'h0b;
    localparam logic [4:0] ADDR_FINE_GAIN = 5'h0c;
    localparam logic [4:0] ADDR_IFACE_CFG = 5'h0d;
    localparam logic [4:0] ADDR_DRIVE_TERM = 5'h10;
    localparam logic [10:0] REG_RESET = 11'h000; // every bit clears
    // bit positions inside the registers
    localparam int BIT_SOFT_RESET = 10; // power_reference_control
    localparam int BIT_EXT_REF = 5;
    localparam int BIT_PDN_CHB = 3;
    localparam int BIT_PDN_CHA = 2;
    localparam int BIT_PDN_GLOBAL = 0;
    localparam int BIT_OVERRIDE = 10; // output_interface_config
    localparam int BIT_BIT_WISE = 7;
    localparam int BIT_LSB_FIRST = 6;
    localparam int BIT_COARSE_GAIN = 5;
    localparam int BIT_RISE_CAPTURE = 4;
    localparam int BIT_SER14 = 2;
    localparam int BIT_SDR = 1;
    localparam int BIT_TWO_WIRE = 0;
    localparam int BIT_OFFSET_BIN = 9; // format_test_pattern
    localparam int PAT_LSB = 5; // pattern field low bit
    localparam logic [2:0] PAT_NORMAL = 3'h0;
    localparam logic [2:0] PAT_DESKEW = 3'h6;
    localparam logic [2:0] PAT_SYNC = 3'h7;
    // strap level codes from the pin level detectors
    localparam logic [1:0] LVL_GND = 2'h0; // ground
    localparam logic [1:0] LVL_LOW_MID = 2'h1; // half, or 3/8 on select
    localparam logic [1:0] LVL_HIGH_MID = 2'h2; // 5/6, or 5/8 on select
    localparam logic [1:0] LVL_FULL = 2'h3; // supply
    localparam int SYNC_STAGES = 2; // flops in each synchroniser
    localparam int SCLK_MAX_MHZ = 20; // fastest shift clock handled
    localparam int CLK_PERIOD_NS = 100; // core clock period
    localparam int SETTLE_NS = 100; // host wait after last edge
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } serial_word_t;
    typedef struct packed {
        logic globalPowerDown;
        logic chanAPowerDown;
        logic chanBPowerDown;
        logic externalRef;
        logic coarseGain;
        logic twoWire;
        logic sdrClock;
        logic serialize14;
        logic captureRising;
        logic lsbFirst;
        logic offsetBinary;
        logic bitWise;
        logic [2:0] testPattern;
        logic [4:0] clockInGain;
        logic [11:0] customPattern;
        logic [2:0] fineGain;
        logic [10:0] driveTermination;
    } converter_cfg_t;
endpackage
`default_nettype wire

// ===== rtl/converter_config_port.sv
`timescale 1ns/100ps
`default_nettype none
module converter_config_port
    import converter_config_pkg::*;
#(
    parameter int SYNC_DEPTH = SYNC_STAGES // flops per synchroniser
) (
    input wire logic clk, // core clock, 10 MHz
    input wire logic rstn, // power-on reset, active low
    input wire logic shiftClk, // host shift clock, link domain
    input wire logic serialSelectN, // select, active low
    input wire logic serialInputLine, // serial data
    input wire logic resetPin, // hardware reset / strap mode pin
    input wire logic [1:0] selectStrapLevel, // level code on select pin
    input wire logic [1:0] modeStrapOne, // level code
    input wire logic [1:0] modeStrapTwo, // level code
    input wire logic [1:0] modeStrapFour, // level code
    input wire logic chanASleepPin, // high powers channel A down
    input wire logic chanBSleepPin, // high powers channel B down
    input wire logic powerDownPin, // high forces global power down
    output logic strapMode, // serial pins act as straps
    output logic writeStrobe, // one pulse per accepted write
    output converter_cfg_t cfg // effective configuration
);

    // ---------------- link domain, falling shift-clock edges ----------------

    logic [WORD_W-2:0] shiftReg; // bits gathered so far in this word
    logic [3:0] bitCount; // position inside the current word
    serial_word_t linkWord; // last completed word, held for the core
    logic linkToggle; // flips once per completed word

    // shift register and bit counter; raising select clears the count so a
    // partial word never completes
    always_ff @(negedge shiftClk or posedge serialSelectN) begin
        if (serialSelectN) begin
            bitCount <= 4'h0;
        end else begin
            shiftReg <= {shiftReg[WORD_W-3:0], serialInputLine};
            bitCount <= bitCount + 4'h1; // wraps, so words may follow back to back
        end
    end

    // edge driven only, so any duty cycle and any shift rate up to 20 MHz works
    // capture of a finished word; the word stays still for the next sixteen
    // edges, long enough for the core to take it even at the top shift rate
    always_ff @(negedge shiftClk or negedge rstn) begin
        if (!rstn) begin
            linkWord <= '0;
            linkToggle <= 1'b0;
        end else if (!serialSelectN && bitCount == 4'hf) begin
            linkWord <= {shiftReg, serialInputLine};
            linkToggle <= ~linkToggle;
        end
    end

    // ---------------- core domain synchronisers ----------------

    logic [SYNC_DEPTH-1:0] toggleSync; // word event crossing
    logic toggleSeen; // last toggle level acted on
    logic [SYNC_DEPTH-1:0] resetSync; // hardware reset pin
    logic [SYNC_DEPTH-1:0] powerSync; // power-down pin
    logic [SYNC_DEPTH-1:0] sleepASync; // channel A sleep pin
    logic [SYNC_DEPTH-1:0] sleepBSync; // channel B sleep pin
    logic [SYNC_DEPTH-1:0] sclkSync; // shift clock used as a strap
    logic [SYNC_DEPTH-1:0] sdataSync; // data line used as a strap
    logic [1:0] selLvl [SYNC_DEPTH]; // select strap level
    logic [1:0] oneLvl [SYNC_DEPTH]; // strap one level
    logic [1:0] twoLvl [SYNC_DEPTH]; // strap two level
    logic [1:0] fourLvl [SYNC_DEPTH]; // strap four level

    // every pin passes two flops before any logic looks at it; only the last
    // stage is read below
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            toggleSync <= '0;
            resetSync <= '0;
            powerSync <= '0;
            sleepASync <= '0;
            sleepBSync <= '0;
            sclkSync <= '0;
            sdataSync <= '0;
            for (int i = 0; i < SYNC_DEPTH; i++) begin
                selLvl[i] <= LVL_GND;
                oneLvl[i] <= LVL_GND;
                twoLvl[i] <= LVL_GND;
                fourLvl[i] <= LVL_GND;
            end
        end else begin
            toggleSync <= {toggleSync[SYNC_DEPTH-2:0], linkToggle};
            resetSync <= {resetSync[SYNC_DEPTH-2:0], resetPin};
            powerSync <= {powerSync[SYNC_DEPTH-2:0], powerDownPin};
            sleepASync <= {sleepASync[SYNC_DEPTH-2:0], chanASleepPin};
            sleepBSync <= {sleepBSync[SYNC_DEPTH-2:0], chanBSleepPin};
            sclkSync <= {sclkSync[SYNC_DEPTH-2:0], shiftClk};
            sdataSync <= {sdataSync[SYNC_DEPTH-2:0], serialInputLine};
            selLvl[0] <= selectStrapLevel;
            oneLvl[0] <= modeStrapOne;
            twoLvl[0] <= modeStrapTwo;
            fourLvl[0] <= modeStrapFour;
            for (int i = 1; i < SYNC_DEPTH; i++) begin
                selLvl[i] <= selLvl[i-1];
                oneLvl[i] <= oneLvl[i-1];
                twoLvl[i] <= twoLvl[i-1];
                fourLvl[i] <= fourLvl[i-1];
            end
        end
    end

    logic pinReset; // synchronised reset pin level
    logic wordEvent; // a new word has crossed over
    assign pinReset = resetSync[SYNC_DEPTH-1];
    assign wordEvent = toggleSync[SYNC_DEPTH-1] != toggleSeen;
    assign strapMode = pinReset;

    // remembers which toggle level has been consumed
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            toggleSeen <= 1'b0;
        end else begin
            toggleSeen <= toggleSync[SYNC_DEPTH-1];
        end
    end

    // ---------------- register bank ----------------

    // maps an address to a bank slot; slot NUM_REGS marks an unmapped address
    function automatic logic [2:0] slotOf(input logic [ADDR_W-1:0] a);
        case (a)
            ADDR_POWER_REF: slotOf = 3'd0;
            ADDR_CLK_GAIN: slotOf = 3'd1;
            ADDR_FORMAT_PAT: slotOf = 3'd2;
            ADDR_CUSTOM_LOW: slotOf = 3'd3;
            ADDR_FINE_GAIN: slotOf = 3'd4;
            ADDR_IFACE_CFG: slotOf = 3'd5;
            ADDR_DRIVE_TERM: slotOf = 3'd6;
            default: slotOf = 3'(NUM_REGS);
        endcase
    endfunction

    logic [DATA_W-1:0] bank [NUM_REGS]; // the seven mapped registers
    logic [2:0] slot; // target of the incoming word
    logic softReset; // incoming word sets the soft reset bit
    logic acceptWord; // word is taken as a register write
    assign slot = slotOf(linkWord.addr);
    assign softReset = slot == 3'd0 && linkWord.data[BIT_SOFT_RESET];
    assign acceptWord = wordEvent && !pinReset;
    assign writeStrobe = acceptWord && slot != 3'(NUM_REGS);

    // writes, soft reset and the reset pin; the soft reset bit itself is never
    // stored, so it reads back as zero right after the write
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                bank[i] <= REG_RESET;
            end
        end else if (pinReset || (acceptWord && softReset)) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                bank[i] <= REG_RESET;
            end
        end else if (writeStrobe) begin
            bank[slot] <= linkWord.data;
        end
    end

    // ---------------- strap decode and priority ----------------

    logic [1:0] selL; // settled select strap level
    logic [1:0] oneL; // settled strap one level
    logic [1:0] twoL; // settled strap two level
    logic [1:0] fourL; // settled strap four level
    logic override; // register bits beat the straps
    assign selL = selLvl[SYNC_DEPTH-1];
    assign oneL = oneLvl[SYNC_DEPTH-1];
    assign twoL = twoLvl[SYNC_DEPTH-1];
    assign fourL = fourLvl[SYNC_DEPTH-1];
    assign override = bank[5][BIT_OVERRIDE];

    converter_cfg_t next_cfg; // configuration for the next edge

    // straps one, two and four act from power-up on because the bank starts
    // at zero, which leaves the override bit low
    always_comb begin
        next_cfg = '0;
        // interface layout, strap one; the unused level falls back to ground
        if (override) begin
            next_cfg.twoWire = bank[5][BIT_TWO_WIRE];
            next_cfg.sdrClock = bank[5][BIT_SDR];
        end else begin
            next_cfg.twoWire = oneL == LVL_HIGH_MID || oneL == LVL_FULL;
            next_cfg.sdrClock = oneL == LVL_HIGH_MID;
        end
        // serialization and capture edge, strap two
        if (override) begin
            next_cfg.serialize14 = bank[5][BIT_SER14];
            next_cfg.captureRising = bank[5][BIT_RISE_CAPTURE];
        end else begin
            next_cfg.serialize14 = twoL == LVL_LOW_MID || twoL == LVL_HIGH_MID;
            next_cfg.captureRising = twoL == LVL_HIGH_MID || twoL == LVL_FULL;
        end
        // bit order and format, strap four
        if (override) begin
            next_cfg.lsbFirst = bank[5][BIT_LSB_FIRST];
            next_cfg.offsetBinary = bank[2][BIT_OFFSET_BIN];
        end else begin
            next_cfg.lsbFirst = fourL == LVL_HIGH_MID || fourL == LVL_FULL;
            next_cfg.offsetBinary = fourL == LVL_LOW_MID || fourL == LVL_HIGH_MID;
        end
        next_cfg.bitWise = bank[5][BIT_BIT_WISE];
        // reference, coarse gain, patterns and power down by mode
        if (pinReset) begin
            next_cfg.externalRef = selL == LVL_GND || selL == LVL_LOW_MID;
            next_cfg.coarseGain = selL == LVL_LOW_MID || selL == LVL_HIGH_MID;
            case ({sclkSync[SYNC_DEPTH-1], sdataSync[SYNC_DEPTH-1]})
                2'b01: next_cfg.testPattern = PAT_SYNC;
                2'b11: next_cfg.testPattern = PAT_DESKEW;
                default: next_cfg.testPattern = PAT_NORMAL;
            endcase
            next_cfg.globalPowerDown = (sclkSync[SYNC_DEPTH-1] && !sdataSync[SYNC_DEPTH-1])
                || powerSync[SYNC_DEPTH-1];
        end else begin
            next_cfg.externalRef = bank[0][BIT_EXT_REF];
            next_cfg.coarseGain = override && bank[5][BIT_COARSE_GAIN];
            next_cfg.testPattern = bank[2][PAT_LSB+2:PAT_LSB];
            next_cfg.globalPowerDown = powerSync[SYNC_DEPTH-1]
                || bank[0][BIT_PDN_GLOBAL];
        end
        // channel sleep pins always act, the register bits add to them
        next_cfg.chanAPowerDown = sleepASync[SYNC_DEPTH-1] || bank[0][BIT_PDN_CHA];
        next_cfg.chanBPowerDown = sleepBSync[SYNC_DEPTH-1] || bank[0][BIT_PDN_CHB];
        // plain register fields
        next_cfg.clockInGain = bank[1][6:2];
        next_cfg.customPattern = {bank[4][0], bank[3]};
        next_cfg.fineGain = bank[4][10:8];
        next_cfg.driveTermination = bank[6];
    end

    // effective configuration, registered so the data outputs come from flops
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cfg <= '0;
        end else begin
            cfg <= next_cfg;
        end
    end

endmodule // converter_config_port
`default_nettype wire
